// ==== verification/sfc_frontend_sva.sv ====
// Property checker for the serial flash command front end.
`timescale 1ns/1ps
module sfc_frontend_sva (
	input wire logic ref_clk, // System clock.
	input wire logic arst_n, // Reset, active low.
	input wire logic cs_n, // Chip select.
	input wire logic si_oe, // Second line enable.
	input wire logic so_oe, // Output enable.
	input wire logic [7:0] cmd_opcode, // Opcode.
	input wire logic [23:0] cmd_addr, // Address.
	input wire logic cmd_start, // Header pulse.
	input wire logic cmd_end, // End pulse.
	input wire logic cmd_abort, // Abort pulse.
	input wire logic wr_latch, // Write latch.
	input wire logic wr_valid // Data byte pulse.
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// A deselected link for eight cycles leaves time for the enables to drop.
	sequence cs_idle_s;
		cs_n [*8];
	endsequence
	oe_idle_a: assert property (cs_idle_s |-> !so_oe && !si_oe)
		else $error("output enable while deselected");
	oe_read_a: assert property (so_oe |-> cmd_opcode inside {8'h1b, 8'h0b, 8'h03, 8'h3b,
		8'h3c, 8'h35, 8'h77, 8'h05, 8'h9f})
		else $error("output driven for a non-read opcode");
	dual_out_a: assert property (si_oe |-> so_oe && cmd_opcode == 8'h3b)
		else $error("second line driven outside dual read");
	addr_top_a: assert property (cmd_start |-> cmd_addr[23:21] == 3'h0)
		else $error("address top bits kept");
	start_known_a: assert property (cmd_start |-> cmd_opcode inside {8'h1b, 8'h0b, 8'h03,
		8'h3b, 8'h20, 8'h52, 8'hd8, 8'h02, 8'ha2, 8'h36, 8'h39, 8'h3c, 8'h33, 8'h34, 8'h35,
		8'h9b, 8'h77, 8'h60, 8'hc7, 8'hb0, 8'hd0, 8'h06, 8'h04, 8'h05, 8'h01, 8'h31, 8'hf0,
		8'h9f, 8'hb9, 8'hab})
		else $error("header accepted for unknown opcode");
	start_pulse_a: assert property (cmd_start |=> !cmd_start)
		else $error("header pulse longer than one cycle");
	abort_frame_a: assert property (cmd_abort |-> cs_n && !cmd_start && !cmd_end)
		else $error("abort without deselect");
	end_frame_a: assert property (cmd_end |-> cs_n ##1 !cmd_end)
		else $error("end pulse while selected");
	latch_set_a: assert property ($rose(wr_latch) |-> cmd_opcode == 8'h06)
		else $error("write latch set by wrong opcode");
	latch_clr_a: assert property ($fell(wr_latch) |-> cmd_opcode inside {8'h04, 8'hf0})
		else $error("write latch cleared by wrong opcode");
	wr_byte_a: assert property (wr_valid |-> cmd_opcode inside {8'h02, 8'ha2, 8'h33, 8'h34,
		8'h9b, 8'h01, 8'h31, 8'hf0})
		else $error("data byte for a command without data");
endmodule // sfc_frontend_sva
bind sfc_frontend sfc_frontend_sva sfc_frontend_sva_i (.ref_clk, .arst_n, .cs_n, .si_oe, .so_oe,
	.cmd_opcode, .cmd_addr, .cmd_start, .cmd_end, .cmd_abort, .wr_latch, .wr_valid);

// ==== verification/sfc_host.sv ====
// Host controller model that frames commands on the serial link.
`timescale 1ns/1ps
module sfc_host (
	output logic cs_n, // Chip select, active low.
	output logic sck, // Serial clock, idle low.
	output logic si_drv, // Host level for the serial input pin.
	output logic so_drv, // Host level for the serial output pin.
	output logic so_en, // High while the host drives the serial output pin.
	input wire logic si_pin, // Resolved serial input pin.
	input wire logic so_pin // Resolved serial output pin.
);
	// Idle state: deselected, clock low as in mode 0.
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si_drv = 1'b0;
		so_drv = 1'b0;
		so_en = 1'b0;
	end
	// Opens a frame; the first rise follows half a period later.
	task automatic start();
		cs_n = 1'b0;
	endtask
	// Mode 0 is single, 1 dual program, 2 dual read; data moves while the clock is low.
	task automatic xfer(input logic [7:0] tx, input int mode, output logic [7:0] rx);
		int i;
		i = 7;
		so_en = (mode == 1);
		while (i >= 0) begin
			if (mode != 0) begin
				so_drv = tx[i];
				si_drv = tx[i-1];
			end else begin
				si_drv = tx[i];
			end
			#80 sck = 1'b1;
			rx[i] = so_pin;
			if (mode != 0) rx[i-1] = si_pin;
			#80 sck = 1'b0;
			i = (mode != 0) ? i - 2 : i - 1;
		end
	endtask
	// Closes the frame, lets go of the output line and inverts the input line so neither shows old data.
	task automatic stop();
		#80 cs_n = 1'b1;
		so_en = 1'b0;
		si_drv = ~si_drv;
	endtask
endmodule // sfc_host

// ==== verification/testbench.sv ====
// Self-checking testbench of the serial flash command front end.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module testbench;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic rd_valid = 1'b0;
	logic [7:0] rd_data = 8'h00;
	logic [7:0] rx, last_wr;
	logic [7:0] rq [$];
	logic tk = 1'b0;
	logic lat = 1'b0;
	int n_errors = 0, n_compared = 0, cyc = 0;
	int n_st, n_en, n_ab, n_wr, saw_so, saw_si;
	wire cs_n, sck, si_drv, so_drv, so_en, si_out, si_oe, so_out, so_oe, rd_ready;
	wire cmd_start, cmd_end, cmd_abort, wr_latch, wr_valid;
	wire [7:0] cmd_opcode, wr_data;
	wire [23:0] cmd_addr;
	// Pin levels from all drivers; a released line shows the inverse of the host value.
	wire si_pin = si_oe ? si_out : si_drv;
	wire so_pin = so_oe ? so_out : (so_en ? so_drv : ~so_drv);
	sfc_frontend sfc_frontend_i (.ref_clk, .arst_n, .cs_n, .sck, .si_in(si_pin), .si_out,
		.si_oe, .so_in(so_pin), .so_out, .so_oe, .cmd_opcode, .cmd_addr, .cmd_start,
		.cmd_end, .cmd_abort, .wr_latch, .wr_data, .wr_valid, .rd_valid, .rd_ready, .rd_data);
	sfc_host sfc_host_i (.cs_n, .sck, .si_drv, .so_drv, .so_en, .si_pin, .so_pin);
	always #10 ref_clk = ~ref_clk;
	// Pulses are counted at the falling edge, where registered outputs are settled.
	always @(negedge ref_clk) begin
		cyc++;
		tk = rd_valid && rd_ready;
		if (cmd_start) n_st++;
		if (cmd_end) n_en++;
		if (cmd_abort) n_ab++;
		if (so_oe) saw_so++;
		if (si_oe) saw_si++;
		if (wr_valid) begin
			n_wr++;
			last_wr = wr_data;
		end
		if (cyc == 30000) begin
			n_errors++;
			end_of_test();
		end
	end
	// Response feeder: offers queued bytes and holds each until the buffer takes it.
	always @(posedge ref_clk) begin
		#1;
		if (tk) void'(rq.pop_front());
		rd_valid = (rq.size() != 0);
		rd_data = (rq.size() != 0) ? rq[0] : 8'h00;
	end
	task automatic frame(input logic [7:0] op, input int nadr, input logic [23:0] adr);
		int k;
		n_st = 0; n_en = 0; n_ab = 0; n_wr = 0; saw_so = 0; saw_si = 0;
		@(posedge ref_clk);
		#1 sfc_host_i.start();
		sfc_host_i.xfer(op, 0, rx);
		for (k = 2; k >= 3 - nadr; k--) sfc_host_i.xfer(adr[k*8 +: 8], 0, rx);
	endtask
	task automatic close();
		sfc_host_i.stop();
		repeat (12) @(posedge ref_clk);
		#1;
	endtask
	// Every known opcode once, with the address bytes it takes.
	task automatic t_decode();
		logic [7:0] ops [30] = '{8'h1b, 8'h0b, 8'h03, 8'h3b,
			8'h20, 8'h52, 8'hd8, 8'h02, 8'ha2,
			8'h36, 8'h39, 8'h3c, 8'h33, 8'h34, 8'h35, 8'h9b, 8'h77,
			8'h60, 8'hc7, 8'hb0, 8'hd0, 8'h06, 8'h04, 8'h05,
			8'h01, 8'h31, 8'hf0, 8'h9f, 8'hb9, 8'hab};
		for (int i = 0; i < 30; i++) begin
			frame(ops[i], (i < 17) ? 3 : 0, 24'hfedcba);
			close();
			if (ops[i] == 8'h06) lat = 1'b1;
			if (ops[i] == 8'h04) lat = 1'b0;
			`CHK("starts", 1, n_st)
			`CHK("ends", 1, n_en)
			`CHK("opcode", ops[i], cmd_opcode)
			if (i < 17) `CHK("address", 24'h1edcba, cmd_addr)
			`CHK("latch", lat, wr_latch)
		end
		$display("t_decode done");
	endtask
	// Unknown opcode followed by a valid one in the same frame.
	task automatic t_unknown();
		frame(8'h00, 0, 24'h0);
		sfc_host_i.xfer(8'h06, 0, rx);
		close();
		`CHK("starts", 0, n_st)
		`CHK("ends", 0, n_en)
		`CHK("latch", 1'b0, wr_latch)
		frame(8'h06, 0, 24'h0);
		close();
		`CHK("latch", 1'b1, wr_latch)
		$display("t_unknown done");
	endtask
	task automatic t_abort();
		frame(8'h02, 1, 24'h120000);
		close();
		`CHK("aborts", 1, n_ab)
		`CHK("starts", 0, n_st)
		`CHK("ends", 0, n_en)
		$display("t_abort done");
	endtask
	// Single and dual program; the output pin must stay an input.
	task automatic t_prog();
		frame(8'h02, 3, 24'h001234);
		sfc_host_i.xfer(8'ha5, 0, rx);
		sfc_host_i.xfer(8'h5a, 0, rx);
		close();
		`CHK("bytes", 2, n_wr)
		`CHK("data", 8'h5a, last_wr)
		`CHK("drive", 0, saw_so)
		frame(8'ha2, 3, 24'h001234);
		sfc_host_i.xfer(8'hc3, 1, rx);
		close();
		`CHK("bytes", 1, n_wr)
		`CHK("dual data", 8'hc3, last_wr)
		`CHK("drive", 0, saw_so)
		$display("t_prog done");
	endtask
	// Three bytes through a two-entry buffer, so the feeder stalls on the third.
	task automatic t_read(input logic [7:0] op, input int ndum, input int mode);
		logic [7:0] ex [3] = '{8'h3c, 8'ha5, 8'h96};
		rq = '{8'h3c, 8'ha5, 8'h96};
		frame(op, 3, 24'h000100);
		for (int k = 0; k < ndum; k++) sfc_host_i.xfer(8'h00, 0, rx);
		for (int k = 0; k < 3; k++) begin
			sfc_host_i.xfer(8'h00, mode, rx);
			`CHK("read byte", ex[k], rx)
		end
		close();
		`CHK("second line", mode == 2, saw_si != 0)
		$display("t_read %0h done", op);
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Reset, then the scenarios in turn.
	initial begin
		repeat (12) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		repeat (3) @(posedge ref_clk);
		t_decode();
		t_unknown();
		t_abort();
		t_prog();
		t_read(8'h0b, 1, 0);
		t_read(8'h03, 0, 0);
		t_read(8'h1b, 2, 0);
		t_read(8'h77, 2, 0);
		t_read(8'h3b, 1, 2);
		end_of_test();
	end
endmodule // testbench

// ==== verilog/sfc_buf.v ====
// Two-entry valid/ready buffer for response bytes.
`timescale 1ns/1ps
module sfc_buf #(
	parameter WIDTH = 8,
	parameter DEPTH = 2,
	parameter AW = 1
) (
	input wire ref_clk, // System clock.
	input wire arst_n, // Asynchronous reset, active low.
	input wire flush, // Empties the buffer.
	input wire in_valid, // Word offered.
	output wire in_ready, // Space for a word.
	input wire [WIDTH-1:0] in_data, // Offered word.
	output wire out_valid, // Word available.
	input wire out_ready, // Consumer takes word.
	output wire [WIDTH-1:0] out_data // Oldest word.
);
	// Fill level at which the buffer refuses further words.
	localparam [AW:0] FULL_CNT = DEPTH;
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ff;
	reg [AW-1:0] rd_ff;
	reg [AW:0] cnt_ff;
	wire push;
	wire pop;
	// Full and empty come straight from the fill count.
	assign in_ready = (cnt_ff != FULL_CNT) && !flush;
	assign out_valid = (cnt_ff != {(AW+1){1'b0}});
	assign out_data = mem[rd_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Pointer and count update.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ff <= {AW{1'b0}};
			rd_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_ff <= {AW{1'b0}};
			rd_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= rd_ff + 1'b1;
			end
			if (push && !pop) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (pop && !push) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end
	// Storage write.
	always @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ff] <= in_data;
		end
	end
endmodule // sfc_buf

// ==== verilog/sfc_frontend.v ====
// Command framing and decoding front end of the serial flash.
// Functional notes
// - Sample on rising, shift out on falling.
// - All bytes travel most significant bit first.
// - Unknown opcode ignored until select cycles.
// - Early deselect aborts, back to idle.
// - 24-bit address, top three bits ignored.
// - Dual commands turn pin direction around.
// - 1Bh: address, two dummies, data.
// - 0Bh: address, one dummy, data.
// - 03h: address, no dummy, data.
// - 3Bh: dual read, one dummy.
// - 20h/52h/D8h block erase, address only.
// - 60h or C7h erase whole array.
// - 02h and A2h program with address, data.
// - B0h suspend, D0h resume, opcode only.
// - 06h sets, 04h clears write latch.
// - 36h/39h protect, 3Ch reads protection.
// - 33h/34h one data byte, 35h reads; code accepts any number of data bytes for 33h/34h.
// - 9Bh programs OTP, 77h reads, two dummies.
// - 05h status read, 01h/31h one byte; code accepts any number of data bytes for 01h/31h.
// - 9Fh identification read, F0h one byte; code accepts any number of data bytes for F0h.
// - B9h power down, ABh wakes.
`timescale 1ns/1ps
`include "sfc_map.vh"
module sfc_frontend #(
	parameter DATA_W = 8
) (
	input wire ref_clk, // System clock, 50 MHz.
	input wire arst_n, // Asynchronous reset, active low.
	input wire cs_n, // Chip select pin, active low.
	input wire sck, // Serial clock pin.
	input wire si_in, // Serial input pin level.
	output reg si_out, // Second output line in dual read.
	output reg si_oe, // Drive enable for the serial input pin.
	input wire so_in, // Serial output pin level, dual program input.
	output reg so_out, // Serial output data.
	output reg so_oe, // Drive enable for the serial output pin.
	output reg [7:0] cmd_opcode, // Decoded opcode of the frame.
	output reg [23:0] cmd_addr, // Address with top bits cleared.
	output reg cmd_start, // Pulse: command header complete.
	output reg cmd_end, // Pulse: frame ended after a good header.
	output reg cmd_abort, // Pulse: frame ended early.
	output reg wr_latch, // Write permission latch level.
	output reg [7:0] wr_data, // Received data byte.
	output reg wr_valid, // Pulse: data byte received.
	input wire rd_valid, // Response byte offered.
	output wire rd_ready, // Response buffer has space.
	input wire [7:0] rd_data // Response byte.
);
	localparam ST_IDLE = 6'b000001;
	localparam ST_OP = 6'b000010;
	localparam ST_ADDR = 6'b000100;
	localparam ST_DUMMY = 6'b001000;
	localparam ST_DATA = 6'b010000;
	localparam ST_IGNORE = 6'b100000;

	wire [3:0] pins;
	wire cs_s;
	wire sck_s;
	wire si_s;
	wire so_s;
	reg sck_d_ff;
	reg cs_d_ff;
	wire rise;
	wire fall;
	wire sel_on;
	wire sel_off;
	reg [5:0] st_ff;
	reg [2:0] bit_ff;
	reg [1:0] byte_ff;
	reg [7:0] sh_ff;
	reg [7:0] tx_ff;
	reg [2:0] tx_cnt_ff;
	reg known;
	reg has_addr;
	reg [1:0] dummies;
	reg [1:0] data_kind;
	reg is_read;
	reg is_dual;
	reg [7:0] op_now;
	wire [7:0] rx_byte;
	wire byte_done;
	wire buf_valid;
	wire [7:0] buf_data;
	reg buf_take;
	reg hdr_ok_ff;
	reg op_pending;
	reg dec_go;
	reg addr_go;
	reg dummy_go;

	sfc_sync #(.WIDTH(4)) u_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.async_in({cs_n, sck, si_in, so_in}),
		.rst_val(4'hf),
		.sync_out(pins)
	);
	assign cs_s = pins[3];
	assign sck_s = pins[2];
	assign si_s = pins[1];
	assign so_s = pins[0];

	sfc_buf #(.WIDTH(8), .DEPTH(`SFC_BUF_DEPTH), .AW(1)) u_buf (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.flush(cs_s),
		.in_valid(rd_valid),
		.in_ready(rd_ready),
		.in_data(rd_data),
		.out_valid(buf_valid),
		.out_ready(buf_take),
		.out_data(buf_data)
	);

	// Edge detection on synchronised pin levels.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_d_ff <= 1'b0;
			cs_d_ff <= 1'b1;
		end else begin
			sck_d_ff <= sck_s;
			cs_d_ff <= cs_s;
		end
	end
	assign rise = !cs_s && sck_s && !sck_d_ff;
	assign fall = !cs_s && !sck_s && sck_d_ff;
	assign sel_on = !cs_s && cs_d_ff;
	assign sel_off = cs_s && !cs_d_ff;

	// Opcode table giving address, dummy and data shape of each command.
	always @* begin
		op_now = cmd_opcode;
		known = 1'b1;
		has_addr = 1'b0;
		dummies = `SFC_DUMMY_NONE;
		data_kind = `SFC_DATA_NONE;
		is_read = 1'b0;
		is_dual = 1'b0;
		case (op_now)
			`SFC_OP_RD_FAST2, `SFC_OP_OTP_RD: begin
				has_addr = 1'b1;
				dummies = `SFC_DUMMY_TWO;
				data_kind = `SFC_DATA_MANY;
				is_read = 1'b1;
			end
			`SFC_OP_RD_FAST1: begin
				has_addr = 1'b1;
				dummies = `SFC_DUMMY_ONE;
				data_kind = `SFC_DATA_MANY;
				is_read = 1'b1;
			end
			`SFC_OP_RD_DUAL: begin
				has_addr = 1'b1;
				dummies = `SFC_DUMMY_ONE;
				data_kind = `SFC_DATA_MANY;
				is_read = 1'b1;
				is_dual = 1'b1;
			end
			`SFC_OP_RD_SLOW, `SFC_OP_RD_PROT, `SFC_OP_RD_LOCK: begin
				has_addr = 1'b1;
				data_kind = `SFC_DATA_MANY;
				is_read = 1'b1;
			end
			`SFC_OP_ER_4K, `SFC_OP_ER_32K, `SFC_OP_ER_64K, `SFC_OP_PROT,
			`SFC_OP_UNPROT: begin
				has_addr = 1'b1;
			end
			`SFC_OP_PROG, `SFC_OP_OTP_PROG: begin
				has_addr = 1'b1;
				data_kind = `SFC_DATA_MANY;
			end
			`SFC_OP_PROG_DUAL: begin
				has_addr = 1'b1;
				data_kind = `SFC_DATA_MANY;
				is_dual = 1'b1;
			end
			`SFC_OP_LOCK, `SFC_OP_FREEZE: begin
				has_addr = 1'b1;
				data_kind = `SFC_DATA_ONE;
			end
			`SFC_OP_RD_STAT, `SFC_OP_RD_ID: begin
				data_kind = `SFC_DATA_MANY;
				is_read = 1'b1;
			end
			`SFC_OP_WR_STAT1, `SFC_OP_WR_STAT2, `SFC_OP_SW_RESET: begin
				data_kind = `SFC_DATA_ONE;
			end
			`SFC_OP_ER_CHIP_A, `SFC_OP_ER_CHIP_B, `SFC_OP_SUSPEND, `SFC_OP_RESUME,
			`SFC_OP_WR_EN, `SFC_OP_WR_DIS, `SFC_OP_PWR_DOWN, `SFC_OP_PWR_UP: begin
				known = 1'b1;
			end
			default: begin
				known = 1'b0;
			end
		endcase
	end

	// Incoming byte assembly, MSB first; dual program takes two bits a clock.
	assign rx_byte = (st_ff == ST_DATA && cmd_opcode == `SFC_OP_PROG_DUAL) ?
		{sh_ff[5:0], so_s, si_s} : {sh_ff[6:0], si_s};
	assign byte_done = rise && ((st_ff == ST_DATA && cmd_opcode == `SFC_OP_PROG_DUAL) ?
		(bit_ff[1:0] == 2'd3) : (bit_ff == 3'd7));

	// Frame parser.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= ST_IDLE;
			bit_ff <= 3'd0;
			byte_ff <= 2'd0;
			sh_ff <= 8'h00;
			cmd_opcode <= 8'h00;
			cmd_addr <= 24'h000000;
			cmd_start <= 1'b0;
			cmd_end <= 1'b0;
			cmd_abort <= 1'b0;
			wr_latch <= 1'b0;
			wr_data <= 8'h00;
			wr_valid <= 1'b0;
			hdr_ok_ff <= 1'b0;
		end else begin
			cmd_start <= 1'b0;
			cmd_end <= 1'b0;
			cmd_abort <= 1'b0;
			wr_valid <= 1'b0;
			// Remembers that this frame carried a complete, known header.
			if (cmd_start) begin
				hdr_ok_ff <= 1'b1;
			end
			if (sel_on) begin
				st_ff <= ST_OP;
				hdr_ok_ff <= 1'b0;
				bit_ff <= 3'd0;
				byte_ff <= 2'd0;
				sh_ff <= 8'h00;
			end else if (sel_off) begin
				if (st_ff == ST_OP || st_ff == ST_ADDR) begin
					cmd_abort <= 1'b1;
				end else if (hdr_ok_ff) begin
					cmd_end <= 1'b1;
				end
				st_ff <= ST_IDLE;
			end else if (rise) begin
				case (st_ff)
					ST_OP: begin
						sh_ff <= rx_byte;
						bit_ff <= bit_ff + 3'd1;
						if (byte_done) begin
							sh_ff <= 8'h00;
							cmd_opcode <= rx_byte;
						end
					end
					ST_ADDR: begin
						sh_ff <= rx_byte;
						bit_ff <= bit_ff + 3'd1;
						if (byte_done) begin
							cmd_addr <= {cmd_addr[15:0], rx_byte} & `SFC_ADDR_MASK;
							byte_ff <= byte_ff + 2'd1;
						end
					end
					ST_DUMMY: begin
						bit_ff <= bit_ff + 3'd1;
						if (byte_done) begin
							byte_ff <= byte_ff + 2'd1;
						end
					end
					ST_DATA: begin
						sh_ff <= rx_byte;
						bit_ff <= byte_done ? 3'd0 : bit_ff + 3'd1;
						if (byte_done && !is_read_op(cmd_opcode)) begin
							wr_data <= rx_byte;
							wr_valid <= 1'b1;
						end
					end
					ST_IGNORE: begin
						st_ff <= ST_IGNORE;
					end
					default: begin
						st_ff <= st_ff;
					end
				endcase
			end else begin
				// Header stage advances one cycle after a byte completes.
				case (st_ff)
					ST_OP: begin
						if (bit_ff == 3'd0 && cmd_start == 1'b0 && op_pending) begin
							st_ff <= ST_IDLE;
						end
					end
					default: begin
						st_ff <= st_ff;
					end
				endcase
			end
			// Decode step after the opcode byte lands.
			if (!sel_on && !sel_off && rise && st_ff == ST_OP && byte_done) begin
				sh_ff <= rx_byte;
			end
			if (dec_go) begin
				sh_ff <= 8'h00;
				byte_ff <= 2'd0;
				if (!known) begin
					st_ff <= ST_IGNORE;
				end else if (has_addr) begin
					st_ff <= ST_ADDR;
				end else begin
					cmd_start <= 1'b1;
					st_ff <= (data_kind != `SFC_DATA_NONE) ? ST_DATA : ST_IGNORE;
					if (op_now == `SFC_OP_WR_EN) begin
						wr_latch <= 1'b1;
					end else if (op_now == `SFC_OP_WR_DIS) begin
						wr_latch <= 1'b0;
					end
				end
			end else if (addr_go) begin
				byte_ff <= 2'd0;
				cmd_start <= 1'b1;
				st_ff <= (dummies != `SFC_DUMMY_NONE) ? ST_DUMMY :
					((data_kind != `SFC_DATA_NONE) ? ST_DATA : ST_IGNORE);
			end else if (dummy_go) begin
				st_ff <= ST_DATA;
			end
		end
	end

	// Decode triggers use the table with the opcode latched a cycle earlier.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			op_pending <= 1'b0;
		end else begin
			op_pending <= rise && st_ff == ST_OP && byte_done && !sel_on && !sel_off;
		end
	end
	always @* begin
		dec_go = op_pending && st_ff == ST_OP && !sel_off && !sel_on;
		addr_go = st_ff == ST_ADDR && byte_ff == 2'd3 && !sel_off && !sel_on;
		dummy_go = st_ff == ST_DUMMY && !sel_off && !sel_on &&
			(byte_ff == dummies_of(cmd_opcode));
	end

	function is_read_op;
		input [7:0] op;
		begin
			is_read_op = (op == `SFC_OP_RD_FAST2) || (op == `SFC_OP_OTP_RD) ||
				(op == `SFC_OP_RD_FAST1) || (op == `SFC_OP_RD_DUAL) ||
				(op == `SFC_OP_RD_SLOW) || (op == `SFC_OP_RD_PROT) ||
				(op == `SFC_OP_RD_LOCK) || (op == `SFC_OP_RD_STAT) ||
				(op == `SFC_OP_RD_ID);
		end
	endfunction

	function [1:0] dummies_of;
		input [7:0] op;
		begin
			if (op == `SFC_OP_RD_FAST2 || op == `SFC_OP_OTP_RD) begin
				dummies_of = `SFC_DUMMY_TWO;
			end else if (op == `SFC_OP_RD_FAST1 || op == `SFC_OP_RD_DUAL) begin
				dummies_of = `SFC_DUMMY_ONE;
			end else begin
				dummies_of = `SFC_DUMMY_NONE;
			end
		end
	endfunction

	// Response shifter: loads a byte at a byte start, changes bits on falling edges.
	wire rd_phase;
	wire dual_rd;
	assign rd_phase = (st_ff == ST_DATA) && is_read_op(cmd_opcode);
	assign dual_rd = (cmd_opcode == `SFC_OP_RD_DUAL);
	always @* begin
		buf_take = rd_phase && fall && (tx_cnt_ff == 3'd0);
	end
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_ff <= 8'h00;
			tx_cnt_ff <= 3'd0;
			so_out <= 1'b0;
			si_out <= 1'b0;
			so_oe <= 1'b0;
			si_oe <= 1'b0;
		end else if (!rd_phase) begin
			tx_cnt_ff <= 3'd0;
			so_oe <= 1'b0;
			si_oe <= 1'b0;
		end else if (fall) begin
			so_oe <= 1'b1;
			si_oe <= dual_rd;
			if (tx_cnt_ff == 3'd0) begin
				tx_ff <= buf_valid ? buf_data : 8'hff;
				so_out <= buf_valid ? buf_data[7] : 1'b1;
				si_out <= buf_valid ? buf_data[6] : 1'b1;
				tx_cnt_ff <= dual_rd ? 3'd2 : 3'd1;
			end else begin
				so_out <= tx_ff[3'd7 - tx_cnt_ff];
				si_out <= tx_ff[3'd6 - tx_cnt_ff];
				tx_cnt_ff <= (dual_rd ? tx_cnt_ff + 3'd2 : tx_cnt_ff + 3'd1) & 3'd7;
			end
		end
	end
endmodule // sfc_frontend

// ==== verilog/sfc_map.vh ====
// Opcode, framing and buffer depth constants of the serial flash command front end.
`ifndef SFC_MAP_VH
`define SFC_MAP_VH
`define SFC_OP_RD_FAST2 8'h1b
`define SFC_OP_RD_FAST1 8'h0b
`define SFC_OP_RD_SLOW 8'h03
`define SFC_OP_RD_DUAL 8'h3b
`define SFC_OP_ER_4K 8'h20
`define SFC_OP_ER_32K 8'h52
`define SFC_OP_ER_64K 8'hd8
`define SFC_OP_ER_CHIP_A 8'h60
`define SFC_OP_ER_CHIP_B 8'hc7
`define SFC_OP_PROG 8'h02
`define SFC_OP_PROG_DUAL 8'ha2
`define SFC_OP_SUSPEND 8'hb0
`define SFC_OP_RESUME 8'hd0
`define SFC_OP_WR_EN 8'h06
`define SFC_OP_WR_DIS 8'h04
`define SFC_OP_PROT 8'h36
`define SFC_OP_UNPROT 8'h39
`define SFC_OP_RD_PROT 8'h3c
`define SFC_OP_LOCK 8'h33
`define SFC_OP_FREEZE 8'h34
`define SFC_OP_RD_LOCK 8'h35
`define SFC_OP_OTP_PROG 8'h9b
`define SFC_OP_OTP_RD 8'h77
`define SFC_OP_RD_STAT 8'h05
`define SFC_OP_WR_STAT1 8'h01
`define SFC_OP_WR_STAT2 8'h31
`define SFC_OP_SW_RESET 8'hf0
`define SFC_OP_RD_ID 8'h9f
`define SFC_OP_PWR_DOWN 8'hb9
`define SFC_OP_PWR_UP 8'hab
`define SFC_ADDR_MASK 24'h1fffff
`define SFC_DUMMY_NONE 2'd0
`define SFC_DUMMY_ONE 2'd1
`define SFC_DUMMY_TWO 2'd2
`define SFC_DATA_NONE 2'd0
`define SFC_DATA_ONE 2'd1
`define SFC_DATA_MANY 2'd2
`define SFC_BUF_DEPTH 2
`endif

// ==== verilog/sfc_sync.v ====
// Two-stage synchroniser for the link pins.
`timescale 1ns/1ps
module sfc_sync #(
	parameter WIDTH = 4
) (
	input wire ref_clk, // System clock.
	input wire arst_n, // Asynchronous reset, active low.
	input wire [WIDTH-1:0] async_in, // Pin levels from outside the domain.
	input wire [WIDTH-1:0] rst_val, // Unused reset helper, kept constant by caller.
	output wire [WIDTH-1:0] sync_out // Levels safe to read.
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] stable_ff;
	genvar i;
	// Each bit passes two flops; only the second is read outside.
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					meta_ff[i] <= 1'b1;
					stable_ff[i] <= 1'b1;
				end else begin
					meta_ff[i] <= async_in[i];
					stable_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate
	assign sync_out = stable_ff;
endmodule // sfc_sync
